// File: lcd_instr_pkg.sv
// Package for the character display instruction core.
// Assumes a single 20 MHz clock and synchronous active-high reset.
package lcd_instr_pkg;
    // Avalon-MM register byte offsets
    localparam logic [3:0] OFF_HOSTIO  = 4'h0; // Write: host transfer
    localparam logic [3:0] OFF_READ    = 4'h4; // Read: last host read data
    localparam logic [3:0] OFF_STATE   = 4'h8; // Read: display state bits
    localparam logic [3:0] OFF_SHIFT   = 4'hc; // Read: display shift amount
    // Host transfer word fields
    localparam int HIO_DATA_LSB = 0;  // Eight bus bits
    localparam int HIO_SEL_BIT  = 8;  // Latch select
    localparam int HIO_RD_BIT   = 9;  // Read when one
    localparam int HIO_NIB_BIT  = 10; // Narrow bus mode
    // Command code positions
    localparam int CMD_CLEAR_BIT = 0;
    localparam int CMD_HOME_BIT  = 1;
    localparam int CMD_ENTRY_BIT = 2;
    localparam int CMD_DISP_BIT  = 3;
    localparam int CMD_SHIFT_BIT = 4;
    // Memory constants
    localparam logic [7:0] SPACE_CODE  = 8'h20;
    localparam logic [6:0] AC_RESET    = 7'h00;
    localparam logic [6:0] LINE1_LAST  = 7'h27;
    localparam logic [6:0] LINE2_FIRST = 7'h40;
    localparam logic [6:0] LINE2_LAST  = 7'h67;
    localparam logic [6:0] ONE_LINE_LAST = 7'h4f;
    localparam int DISP_RAM_WORDS = 128;
    localparam int GLYPH_RAM_WORDS = 64;
    // Execution times in ns, converted to 50 ns cycles
    localparam int CLK_NS       = 50;
    localparam int SHORT_EXEC_NS = 39000;
    localparam int SHORT_EXEC_CYC = (SHORT_EXEC_NS + CLK_NS - 1) / CLK_NS;
    localparam int BLINK_NS     = 400000000;
    localparam int BLINK_CYC    = BLINK_NS / CLK_NS;
    // Host transfer carrier
    typedef struct packed {
        logic       nibble; // Narrow bus transfer
        logic       rd;     // Read request
        logic       sel;    // Latch select: 0 command, 1 data
        logic [7:0] data;   // Bus bits
    } host_xfer_t;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_FILL  = 4'b0010,
        ST_WAIT  = 4'b0100,
        ST_DONE  = 4'b1000
    } exec_state_t;
endpackage : lcd_instr_pkg

// File: char_lcd_instruction_core.sv
// Instruction interpreter of a character display controller.
// Host transfers arrive as Avalon-MM writes at OFF_HOSTIO; one clock.
`timescale 1ns/1ps
`default_nettype none
module char_lcd_instruction_core
    import lcd_instr_pkg::*;
#(
    parameter int EXEC_CYC  = SHORT_EXEC_CYC, // Short command time
    parameter int BLINK_DIV = BLINK_CYC       // Blink half period
) (
    input  wire logic        mclk,          // 20 MHz clock
    input  wire logic        rst,           // Sync reset, high
    input  wire logic [3:0]  address,       // Avalon byte address
    input  wire logic        read,          // Avalon read
    input  wire logic        write,         // Avalon write
    input  wire logic [31:0] writedata,     // Avalon write data
    output logic [31:0]      readdata,      // Avalon read data
    output logic             waitrequest,   // Avalon wait
    input  wire logic        two_line,      // Two-line display mode
    output logic             display_on,    // Whole display enabled
    output logic             cursor_on,     // Cursor shown
    output logic             blink_phase,   // Cursor shows all ones
    output logic             busy           // Internal op running
);
    // Refuse timing values that the counters cannot serve
    if (EXEC_CYC < 1 || BLINK_DIV < 2) begin : g_bad_timing
        $error("char_lcd_instruction_core: bad timing parameter");
    end

    logic [7:0]  display_ram [DISP_RAM_WORDS];
    logic [7:0]  glyph_ram [GLYPH_RAM_WORDS];
    logic [6:0]  address_counter;
    logic        glyph_sel;        // Counter points into glyph RAM
    logic        inc_dir;
    logic        auto_shift_bit;
    logic [6:0]  disp_shift;
    logic [7:0]  command_latch;
    logic [7:0]  data_latch;
    logic [7:0]  rd_data;
    logic        nib_half;         // Upper nibble held
    logic [3:0]  nib_upper;
    logic        pending;          // A full byte awaits execution
    logic        pend_sel;
    logic        pend_rd;
    logic [6:0]  fill_idx;
    logic [31:0] exec_cnt;
    logic [31:0] blink_cnt;
    exec_state_t state;
    host_xfer_t  xfer;

    assign xfer = writedata[10:0];

    // Stepped counter with two-line wrap
    function automatic logic [6:0] step_ac(input logic [6:0] ac,
                                           input logic up, input logic two);
        logic [6:0] r;
        r = up ? 7'(ac + 7'h01) : 7'(ac - 7'h01);
        if (two && up && ac == LINE1_LAST) r = LINE2_FIRST;
        if (two && up && ac == LINE2_LAST) r = AC_RESET;
        if (two && !up && ac == LINE2_FIRST) r = LINE1_LAST;
        if (two && !up && ac == AC_RESET) r = LINE2_LAST;
        if (!two && up && ac == ONE_LINE_LAST) r = AC_RESET;
        if (!two && !up && ac == AC_RESET) r = ONE_LINE_LAST;
        return r;
    endfunction : step_ac

    // Bus slave: one wait cycle for reads and writes, so read data comes from a flop
    always_ff @(posedge mclk) begin
        if (rst) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
        end else begin
            waitrequest <= !((read || write) && waitrequest);
            if (read && waitrequest) begin
                unique case (address)
                    OFF_READ:  readdata <= {24'h000000, rd_data};
                    OFF_STATE: readdata <= {26'h0, glyph_sel, auto_shift_bit,
                                            inc_dir, blink_phase, cursor_on,
                                            display_on};
                    OFF_SHIFT: readdata <= {25'h0, disp_shift};
                    default:   readdata <= 32'h0000_0000; // Unmapped
                endcase
            end
        end
    end

    // Host transfer capture; one byte or two nibbles
    logic take;
    assign take = write && !waitrequest && address == OFF_HOSTIO;
    always_ff @(posedge mclk) begin
        if (rst) begin
            nib_half  <= 1'b0;
            nib_upper <= 4'h0;
            pending   <= 1'b0;
            pend_sel  <= 1'b0;
            pend_rd   <= 1'b0;
            command_latch <= 8'h00;
            data_latch    <= 8'h00;
        end else begin
            pending <= 1'b0;
            if (take) begin
                if (xfer.nibble && !nib_half) begin
                    nib_half  <= 1'b1;
                    nib_upper <= xfer.data[7:4];
                end else begin
                    nib_half <= 1'b0;
                    pending  <= 1'b1;
                    pend_sel <= xfer.sel;
                    pend_rd  <= xfer.rd;
                    if (xfer.sel) data_latch <= xfer.nibble ?
                        {nib_upper, xfer.data[7:4]} : xfer.data;
                    else command_latch <= xfer.nibble ?
                        {nib_upper, xfer.data[7:4]} : xfer.data;
                end
            end
        end
    end

    // Status byte: busy on top line, counter below
    logic [7:0] status_byte;
    assign status_byte = {busy, address_counter};

    // Executor: command decode, RAM access, clear fill, busy timing
    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= ST_IDLE;
            busy  <= 1'b0;
            address_counter <= AC_RESET;
            glyph_sel <= 1'b0;
            inc_dir   <= 1'b1;
            auto_shift_bit <= 1'b0;
            disp_shift <= 7'h00;
            display_on <= 1'b0;
            cursor_on  <= 1'b0;
            rd_data    <= 8'h00;
            fill_idx   <= 7'h00;
            exec_cnt   <= 32'd0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (pending && pend_rd && !pend_sel) begin
                        // Status answer is served below, in any state
                    end else if (pending) begin
                        busy     <= 1'b1;
                        exec_cnt <= 32'(EXEC_CYC);
                        state    <= ST_WAIT;
                        if (pend_sel) begin
                            if (glyph_sel) begin
                                if (pend_rd)
                                    rd_data <= glyph_ram[address_counter[5:0]];
                                else
                                    glyph_ram[address_counter[5:0]] <=
                                        data_latch;
                                address_counter <= {1'b0,
                                    6'(inc_dir ? address_counter[5:0] + 6'h1
                                               : address_counter[5:0] - 6'h1)};
                            end else begin
                                if (pend_rd)
                                    rd_data <= display_ram[address_counter];
                                else
                                    display_ram[address_counter] <= data_latch;
                                address_counter <=
                                    step_ac(address_counter, inc_dir, two_line);
                                if (!pend_rd && auto_shift_bit)
                                    disp_shift <= inc_dir ?
                                        7'(disp_shift + 7'h01) :
                                        7'(disp_shift - 7'h01);
                            end
                        end else if (command_latch[7:5] != 3'b000) begin
                            // Address-set and function commands: not served
                            // here; the host still sees a busy period
                        end else if (command_latch[CMD_SHIFT_BIT]) begin
                            if (command_latch[3])
                                disp_shift <= command_latch[2] ?
                                    7'(disp_shift - 7'h01) :
                                    7'(disp_shift + 7'h01);
                            else
                                address_counter <= step_ac(address_counter,
                                    command_latch[2], two_line);
                        end else if (command_latch[CMD_DISP_BIT]) begin
                            display_on <= command_latch[2];
                            cursor_on  <= command_latch[1];
                        end else if (command_latch[CMD_ENTRY_BIT]) begin
                            inc_dir        <= command_latch[1];
                            auto_shift_bit <= command_latch[0];
                        end else if (command_latch[CMD_HOME_BIT]) begin
                            address_counter <= AC_RESET;
                            glyph_sel  <= 1'b0;
                            disp_shift <= 7'h00;
                        end else if (command_latch[CMD_CLEAR_BIT]) begin
                            address_counter <= AC_RESET;
                            glyph_sel  <= 1'b0;
                            disp_shift <= 7'h00;
                            inc_dir    <= 1'b1;
                            fill_idx   <= 7'h00;
                            state      <= ST_FILL;
                        end
                    end
                end
                ST_FILL: begin
                    display_ram[fill_idx] <= SPACE_CODE;
                    fill_idx <= 7'(fill_idx + 7'h01);
                    if (fill_idx == 7'(DISP_RAM_WORDS - 1)) state <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (exec_cnt <= 32'd1) state <= ST_DONE;
                    else exec_cnt <= exec_cnt - 32'd1;
                end
                ST_DONE: begin
                    busy  <= 1'b0;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
            // Polling must work while busy, so status is not state-bound
            if (pending && pend_rd && !pend_sel)
                rd_data <= status_byte;
        end
    end

    // Blink divider; phase toggles only while blink is enabled
    logic blink_en;
    always_ff @(posedge mclk) begin
        if (rst) begin
            blink_en    <= 1'b0;
            blink_cnt   <= 32'd0;
            blink_phase <= 1'b0;
        end else begin
            if (state == ST_IDLE && pending && !pend_sel && !pend_rd &&
                command_latch[7:3] == 5'b00001)
                blink_en <= command_latch[0];
            if (!blink_en) begin
                blink_phase <= 1'b0;
                blink_cnt   <= 32'd0;
            end else if (blink_cnt == 32'(BLINK_DIV - 1)) begin
                blink_cnt   <= 32'd0;
                blink_phase <= !blink_phase;
            end else begin
                blink_cnt <= blink_cnt + 32'd1;
            end
        end
    end

    // Checks
    busy_clear_a: assert property (@(posedge mclk) disable iff (rst)
        state == ST_FILL |-> busy)
        else $error("busy low during clear fill");
    clear_home_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(state == ST_FILL) |-> address_counter == AC_RESET && inc_dir)
        else $error("clear did not home counter");
    home_shift_a: assert property (@(posedge mclk) disable iff (rst)
        state == ST_IDLE && pending && !pend_sel && !pend_rd &&
        command_latch[7:1] == 7'h01 |=> disp_shift == 7'h00 &&
        address_counter == AC_RESET)
        else $error("home did not reset shift");
    shift_keep_a: assert property (@(posedge mclk) disable iff (rst)
        state == ST_IDLE && pending && !pend_sel && !pend_rd &&
        command_latch[7:3] == 5'b00011 |=> $stable(address_counter))
        else $error("display shift moved counter");
    busy_rise_a: assert property (@(posedge mclk) disable iff (rst)
        state == ST_IDLE && pending && !(pend_rd && !pend_sel) |=> busy)
        else $error("busy not raised");
    busy_len_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(busy) |-> busy [*8])
        else $error("busy too short");
    disp_bit_a: assert property (@(posedge mclk) disable iff (rst)
        state == ST_IDLE && pending && !pend_sel && !pend_rd &&
        command_latch[7:3] == 5'b00001 |=> display_on == $past(command_latch[2]))
        else $error("display bit not applied");
    nib_pair_a: assert property (@(posedge mclk) disable iff (rst)
        take && xfer.nibble && !nib_half |=> !pending && nib_half)
        else $error("nibble pairing broken");
    cv_clear_c: cover property (@(posedge mclk) disable iff (rst)
        state == ST_FILL);
    cv_nibble_c: cover property (@(posedge mclk) disable iff (rst)
        nib_half && take);
    cv_blink_c: cover property (@(posedge mclk) disable iff (rst)
        blink_phase);
endmodule : char_lcd_instruction_core
`default_nettype wire

// File: host_model.sv
// Host processor model driving the block's Avalon-MM port.
// Assumes the block's clock; tasks are called by the bench.
`timescale 1ns/1ps
`default_nettype none
module host_model
    import lcd_instr_pkg::*;
(
    input  wire logic        mclk,        // Bus clock
    input  wire logic        waitrequest, // Slave wait
    input  wire logic        busy,        // Block busy pin
    output logic [3:0]       address,     // Byte address
    output logic             read,        // Read strobe
    output logic             write,       // Write strobe
    output logic [31:0]      writedata    // Write data
);
    // Idle bus from time zero
    initial begin
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
    end

    // One bus cycle; request held until waitrequest is seen low
    task automatic xfer(input logic rd, input logic [3:0] a,
                        input logic [31:0] d);
        @(posedge mclk);
        address   <= a;
        read      <= rd;
        write     <= !rd;
        writedata <= d;
        // Only the bench watchdog ends a wait that never completes
        do begin
            @(posedge mclk);
        end while (waitrequest !== 1'b0);
        read  <= 1'b0;
        write <= 1'b0;
    endtask : xfer

    // Host transfer, then wait until the block is idle again
    task automatic send(input logic nib, input logic rd,
                        input logic sel, input logic [7:0] b);
        xfer(1'b0, OFF_HOSTIO, {21'h0, nib, rd, sel, b});
        repeat (4) @(posedge mclk);
        // A new command while busy would be unsafe
        while (busy !== 1'b0) begin
            @(posedge mclk);
        end
        @(posedge mclk);
    endtask : send
endmodule : host_model
`default_nettype wire

// File: char_lcd_instruction_core_tb_top.sv
// Self-checking bench for the instruction core.
// Assumes host_model drives the bus; reads are checked from a queue.
`timescale 1ns/1ps
`default_nettype none
module char_lcd_instruction_core_tb_top
    import lcd_instr_pkg::*;
;
    localparam int EXEC = 8;
    typedef struct {
        logic [31:0] v;
        logic [31:0] m;
        string       nm;
    } exp_t;
    logic        mclk, rst, two_line, read, write, waitrequest;
    logic        display_on, cursor_on, blink_phase, busy, bb;
    logic [3:0]  address;
    logic [31:0] writedata, readdata;
    logic [7:0]  r8;
    exp_t        exq[$];
    int          n_errors, tests_run, n;

    // Clock of 50 ns
    initial mclk = 1'b0;
    always #25 mclk = ~mclk;

    char_lcd_instruction_core #(.EXEC_CYC(EXEC), .BLINK_DIV(4)) dut_u (
        .mclk(mclk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .two_line(two_line),
        .display_on(display_on), .cursor_on(cursor_on),
        .blink_phase(blink_phase), .busy(busy));
    host_model host_u (
        .mclk(mclk), .waitrequest(waitrequest), .busy(busy),
        .address(address), .read(read), .write(write),
        .writedata(writedata));

    task automatic finish_test();
        if (n_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // Oldest note is compared at each completing read
    always @(posedge mclk) begin
        exp_t x;
        if (read === 1'b1 && waitrequest === 1'b0) begin
            if (exq.size() == 0) begin
                chk("spare read", 32'h0, 32'h1);
            end else begin
                x = exq.pop_front();
                chk(x.nm, x.v & x.m, readdata & x.m);
            end
        end
    end

    task automatic rdchk(input logic [3:0] a, input logic [31:0] v,
                         input logic [31:0] m, input string nm);
        exq.push_back('{v, m, nm});
        host_u.xfer(1'b1, a, 32'h0);
    endtask : rdchk

    // Status request, then fetch of the latched answer
    task automatic stat(input logic [7:0] v, input logic [7:0] m);
        host_u.xfer(1'b0, OFF_HOSTIO, 32'h200);
        repeat (3) @(posedge mclk);
        rdchk(OFF_READ, {24'h0, v}, {24'h0, m}, "status");
    endtask : stat

    task automatic cmd(input logic [7:0] b);
        host_u.send(1'b0, 1'b0, 1'b0, b);
    endtask : cmd

    task automatic ramrd(input logic [7:0] v);
        host_u.send(1'b0, 1'b1, 1'b1, 8'h00);
        rdchk(OFF_READ, {24'h0, v}, 32'hff, "ram byte");
    endtask : ramrd

    // Main sequence
    initial begin
        rst = 1'b1;
        two_line = 1'b1;
        n_errors = 0;
        tests_run = 0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        void'($urandom(32'h9fb8));
        r8 = 8'($urandom);
        rdchk(OFF_STATE, 32'h08, 32'h3b, "reset state");
        rdchk(4'h2, 32'h0, 32'hffffffff, "unmapped");
        cmd(8'h0f);
        chk("display_on", 32'h1, {31'h0, display_on});
        chk("cursor_on", 32'h1, {31'h0, cursor_on});
        bb = blink_phase;
        n = 0;
        while (blink_phase === bb && n < 12) begin
            @(posedge mclk);
            n++;
        end
        chk("blink toggle", 32'h1, {31'h0, n < 12});
        cmd(8'h0e);
        repeat (10) @(posedge mclk);
        chk("blink off", 32'h0, {31'h0, blink_phase});
        cmd(8'h08);
        chk("display off", 32'h0, {31'h0, display_on});
        rdchk(OFF_STATE, 32'h08, 32'h0b, "cursor off");
        // Random byte written, cursor walks back, byte read again
        host_u.send(1'b0, 1'b0, 1'b1, r8);
        stat(8'h01, 8'hff);
        cmd(8'h10);
        stat(8'h00, 8'hff);
        ramrd(r8);
        stat(8'h01, 8'hff);
        host_u.send(1'b1, 1'b0, 1'b0, 8'h10);
        host_u.send(1'b1, 1'b0, 1'b0, 8'h40);
        stat(8'h02, 8'hff);
        cmd(8'h04);
        rdchk(OFF_STATE, 32'h0, 32'h18, "entry dec");
        host_u.send(1'b0, 1'b0, 1'b1, 8'h41);
        stat(8'h01, 8'hff);
        cmd(8'h07);
        host_u.send(1'b0, 1'b0, 1'b1, 8'h42);
        rdchk(OFF_SHIFT, 32'h1, 32'hff, "auto shift");
        host_u.send(1'b0, 1'b1, 1'b1, 8'h00);
        rdchk(OFF_SHIFT, 32'h1, 32'hff, "read no shift");
        cmd(8'h1c);
        rdchk(OFF_SHIFT, 32'h0, 32'hff, "shift right");
        stat(8'h03, 8'hff);
        cmd(8'h18);
        rdchk(OFF_SHIFT, 32'h1, 32'hff, "shift left");
        cmd(8'h03);
        stat(8'h00, 8'hff);
        rdchk(OFF_SHIFT, 32'h0, 32'hff, "home shift");
        ramrd(r8);
        // Busy length of a short command
        host_u.xfer(1'b0, OFF_HOSTIO, 32'h02);
        n = 0;
        repeat (40) begin
            @(posedge mclk);
            if (busy === 1'b1)
                n++;
        end
        chk("busy cycles", EXEC + 1, n);
        // Clear while decrementing; status read during the fill
        cmd(8'h04);
        host_u.xfer(1'b0, OFF_HOSTIO, 32'h01);
        stat(8'h80, 8'h80);
        repeat (200) @(posedge mclk);
        stat(8'h00, 8'hff);
        rdchk(OFF_STATE, 32'h08, 32'h18, "clear dir");
        ramrd(8'h20);
        ramrd(8'h20);
        // Forty steps right leave the first line
        cmd(8'h03);
        for (int i = 0; i < 40; i++) begin
            cmd(8'h14);
        end
        stat(8'h40, 8'hff);
        // One-line mode: a left step from zero wraps to the line end
        cmd(8'h03);
        two_line <= 1'b0;
        cmd(8'h10);
        stat(8'h4f, 8'hff);
        finish_test();
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (40000) @(posedge mclk);
        n_errors++;
        finish_test();
    end
endmodule : char_lcd_instruction_core_tb_top
`default_nettype wire
